/* File: contact_source_model.sv */
// contact terminal and analog source model
`timescale 1ns/1ps
module contact_source_model
   import trim_hold_pkg::*;
(
   input wire logic aclk,
   input wire logic [N_TERM-1:0] term_cmd,
   input wire logic signed [REF_W-1:0] ana_cmd,
   output logic [N_TERM-1:0] contact_input_terminal,
   output logic signed [REF_W-1:0] analog_ref
);
   // contacts follow the command one edge late, as a debounced input would
   always_ff @(posedge aclk)
   begin
      contact_input_terminal <= term_cmd;
      analog_ref <= ana_cmd;
   end
endmodule

/* File: frequency_reference_trim_hold.sv */
// reference trim, sample/hold and source select with axi4-lite registers
//
// Summary of operation
// - up alone adds trim level; down alone subtracts trim level.
// - both trim inputs on or both off: reference passes unchanged.
// - trim level is percent of max frequency, 0 to 100, resets to 10.
// - trim acts only for positive reference taken from analog input.
// - a negative result of subtraction is clamped to zero.
// - trim up is code 1C, trim down 1D, assigned as a pair.
// - only one trim code assigned raises the input selection error.
// - sample/hold code 1E captures analog reference 100ms after assertion.
// - sample/hold must stay on 100ms; earlier release holds nothing.
// - held reference is lost at power loss or reset.
// - sample/hold with ramp hold, up/down or trim raises the error.
// - source select code 2 takes effect only while the drive is stopped.
// - select off: terminals give reference and run; on: option card.
`timescale 1ns/1ps
module frequency_reference_trim_hold
   import trim_hold_pkg::*;
#(
   parameter int HOLD_COUNT = HOLD_CYCLES
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [N_TERM-1:0] contact_input_terminal,
   input wire logic signed [REF_W-1:0] analog_ref,
   input wire logic signed [REF_W-1:0] comm_ref,
   input wire logic comm_run,
   input wire logic terminal_run,
   input wire logic drive_stopped,
   output ref_out_t ref_out,
   output logic invalid_input_selection_error,
   output logic hold_active,
   output logic irq
);
   // ----------------------------------------
   // configuration state
   // ----------------------------------------
   logic [6:0] trim_level_reg;
   logic [15:0] max_output_frequency_reg;
   logic [1:0] reference_source_select_reg;
   logic [1:0] run_source_select_reg;
   logic [CODE_W-1:0] input_function_select_reg [N_TERM];
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;

   function automatic logic assigned(input logic [CODE_W-1:0] sel [N_TERM], input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_TERM; i++)
         hit = hit | (sel[i] == code);
      return hit;
   endfunction

   function automatic logic level(input logic [CODE_W-1:0] sel [N_TERM], input logic [N_TERM-1:0] pins,
                                  input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < N_TERM; i++)
         hit = hit | ((sel[i] == code) & pins[i]);
      return hit;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[8*b +: 8] = nw[8*b +: 8];
      return r;
   endfunction

   // ----------------------------------------
   // axi4-lite write path
   // ----------------------------------------
   logic aw_full_reg;
   logic w_full_reg;
   logic [ADDR_W-1:0] aw_addr_reg;
   logic [DATA_W-1:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_go;
   logic wr_hit;
   logic [31:0] wr_word;
   logic [IRQ_W-1:0] irq_set;

   assign s_axi_awready = !aw_full_reg;
   assign s_axi_wready = !w_full_reg;
   assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;
   assign wr_hit = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= OFS_FSEL0 + 8'h24)
                   && (aw_addr_reg != OFS_STATUS) && (aw_addr_reg != 8'h1C);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_full_reg <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         else if (wr_go)
            w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // strobe merge kept combinational so the clocked block stays non-blocking
   always_comb
   begin
      case (aw_addr_reg)
         OFS_TRIM: wr_word = merge({25'h0, trim_level_reg}, w_data_reg, w_strb_reg);
         OFS_MAXF: wr_word = merge({16'h0, max_output_frequency_reg}, w_data_reg, w_strb_reg);
         OFS_REF_SRC: wr_word = merge({30'h0, reference_source_select_reg}, w_data_reg, w_strb_reg);
         OFS_RUN_SRC: wr_word = merge({30'h0, run_source_select_reg}, w_data_reg, w_strb_reg);
         OFS_IRQ_MASK: wr_word = merge({29'h0, irq_mask_reg}, w_data_reg, w_strb_reg);
         default: wr_word = w_data_reg;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trim_level_reg <= TRIM_RESET;
         max_output_frequency_reg <= MAXF_RESET;
         reference_source_select_reg <= SRC_TERMINAL;
         run_source_select_reg <= SRC_TERMINAL;
         irq_mask_reg <= '0;
         for (int i = 0; i < N_TERM; i++)
            input_function_select_reg[i] <= 8'h00;
      end
      else if (wr_go && wr_hit)
      begin
         case (aw_addr_reg)
            OFS_TRIM:
               // out of range writes saturate rather than wrap
               trim_level_reg <= (wr_word > 32'(TRIM_MAX)) ? TRIM_MAX : wr_word[6:0];
            OFS_MAXF:
               max_output_frequency_reg <= wr_word[15:0];
            OFS_REF_SRC:
               reference_source_select_reg <= wr_word[1:0];
            OFS_RUN_SRC:
               run_source_select_reg <= wr_word[1:0];
            OFS_IRQ_MASK:
               irq_mask_reg <= wr_word[IRQ_W-1:0];
            default:
            begin
               if (aw_addr_reg >= OFS_FSEL0 && w_strb_reg[0])
                  input_function_select_reg[4'((aw_addr_reg - OFS_FSEL0) >> 2)] <= w_data_reg[7:0];
            end
         endcase
      end
   end

   // ----------------------------------------
   // input assignment check
   // ----------------------------------------
   logic has_tu;
   logic has_td;
   logic has_sh;
   logic err_next;
   assign has_tu = assigned(input_function_select_reg, FN_TRIM_UP);
   assign has_td = assigned(input_function_select_reg, FN_TRIM_DN);
   assign has_sh = assigned(input_function_select_reg, FN_SAMPLE_HOLD);
   assign err_next = (has_tu != has_td)
      || (has_sh && (has_tu || has_td || assigned(input_function_select_reg, FN_RAMP_HOLD)
      || assigned(input_function_select_reg, FN_UP) || assigned(input_function_select_reg, FN_DOWN)));

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         invalid_input_selection_error <= 1'b0;
      else
         invalid_input_selection_error <= err_next;
   end

   // ----------------------------------------
   // sample and hold
   // ----------------------------------------
   sh_state_t sh_state_reg;
   logic [31:0] sh_cnt_reg;
   logic signed [15:0] held_ref_reg;
   logic sh_in;
   logic sh_capture;
   assign sh_in = has_sh && level(input_function_select_reg, contact_input_terminal, FN_SAMPLE_HOLD);
   assign sh_capture = (sh_state_reg == SH_WAIT) && sh_in && (sh_cnt_reg == 32'(HOLD_COUNT - 1));
   assign hold_active = (sh_state_reg == SH_HELD);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sh_state_reg <= SH_IDLE;
         sh_cnt_reg <= 32'h00000000;
         held_ref_reg <= 16'sh0000;
      end
      else if (!sh_in)
      begin
         // early release abandons the sample
         sh_state_reg <= SH_IDLE;
         sh_cnt_reg <= 32'h00000000;
      end
      else
      begin
         case (sh_state_reg)
            SH_IDLE:
            begin
               sh_state_reg <= SH_WAIT;
               sh_cnt_reg <= 32'h00000000;
            end
            SH_WAIT:
            begin
               sh_cnt_reg <= sh_cnt_reg + 32'h00000001;
               if (sh_capture)
               begin
                  sh_state_reg <= SH_HELD;
                  held_ref_reg <= analog_ref;
               end
            end
            SH_HELD:
               sh_state_reg <= SH_HELD;
            default:
               sh_state_reg <= SH_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // source select and reference path
   // ----------------------------------------
   logic opt_reg;
   logic opt_in;
   logic [22:0] trim_prod;
   logic [15:0] trim_amt_reg;
   logic signed [15:0] base;
   logic trim_on;
   logic tu;
   logic td;
   logic signed [16:0] sum;
   logic signed [16:0] diff;
   logic signed [15:0] freq_next;

   assign opt_in = level(input_function_select_reg, contact_input_terminal, FN_SRC_SEL);
   // widen before multiplying, a 16-bit product would wrap at full scale
   assign trim_prod = 23'(max_output_frequency_reg) * 23'(trim_level_reg);
   assign base = hold_active ? held_ref_reg : analog_ref;
   assign trim_on = !opt_reg && (reference_source_select_reg == SRC_TERMINAL) && (base > 16'sh0000);
   assign tu = level(input_function_select_reg, contact_input_terminal, FN_TRIM_UP);
   assign td = level(input_function_select_reg, contact_input_terminal, FN_TRIM_DN);
   assign sum = 17'(base) + 17'(trim_amt_reg);
   assign diff = 17'(base) - 17'(trim_amt_reg);

   always_comb
   begin
      if (opt_reg)
         freq_next = comm_ref;
      else if (trim_on && tu && !td)
         freq_next = (sum > REF_CEIL) ? REF_CEIL[15:0] : sum[15:0];
      else if (trim_on && td && !tu)
         freq_next = (diff < 17'sh00000) ? 16'sh0000 : diff[15:0];
      else
         freq_next = base;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         opt_reg <= 1'b0;
         trim_amt_reg <= 16'h0000;
         ref_out <= '0;
      end
      else
      begin
         // switching while running would jump the speed reference
         if (drive_stopped)
            opt_reg <= opt_in;
         trim_amt_reg <= 16'(trim_prod / PCT_DIV);
         ref_out.freq <= freq_next;
         ref_out.run <= opt_reg ? comm_run : terminal_run;
         ref_out.option <= opt_reg;
      end
   end

   // ----------------------------------------
   // interrupts
   // ----------------------------------------
   logic err_seen_reg;
   assign irq_set = {(opt_reg != ref_out.option), sh_capture, (err_next && !err_seen_reg)};
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_reg <= '0;
         err_seen_reg <= 1'b0;
      end
      else
      begin
         err_seen_reg <= err_next;
         // a new event wins over a clear in the same cycle
         if (wr_go && aw_addr_reg == OFS_IRQ_STAT && w_strb_reg[0])
            irq_stat_reg <= (irq_stat_reg & ~w_data_reg[IRQ_W-1:0]) | irq_set;
         else
            irq_stat_reg <= irq_stat_reg | irq_set;
      end
   end

   // ----------------------------------------
   // axi4-lite read path
   // ----------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr)
            OFS_TRIM: s_axi_rdata <= {25'h0, trim_level_reg};
            OFS_MAXF: s_axi_rdata <= {16'h0, max_output_frequency_reg};
            OFS_REF_SRC: s_axi_rdata <= {30'h0, reference_source_select_reg};
            OFS_RUN_SRC: s_axi_rdata <= {30'h0, run_source_select_reg};
            OFS_STATUS: s_axi_rdata <= {ref_out.freq, 13'h0, ref_out.option, hold_active,
                                        invalid_input_selection_error};
            OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_reg};
            OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_reg};
            default:
            begin
               if (s_axi_araddr >= OFS_FSEL0 && s_axi_araddr <= OFS_FSEL0 + 8'h24 && s_axi_araddr[1:0] == 2'h0)
                  s_axi_rdata <= {24'h0, input_function_select_reg[4'((s_axi_araddr - OFS_FSEL0) >> 2)]};
               else
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= RESP_SLVERR;
               end
            end
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_trim_up;
      @(posedge aclk) disable iff (!aresetn)
      (trim_on && tu && !td && sum <= REF_CEIL) |=> ref_out.freq == $past(base) + $past(trim_amt_reg);
   endproperty
   a_trim_up: assert property (p_trim_up) else $error("trim up sum wrong");

   property p_trim_pass;
      @(posedge aclk) disable iff (!aresetn)
      (!opt_reg && tu == td) |=> ref_out.freq == $past(base);
   endproperty
   a_trim_pass: assert property (p_trim_pass) else $error("reference not passed");

   property p_trim_reset;
      @(posedge aclk) !aresetn |=> trim_level_reg == TRIM_RESET && trim_level_reg <= TRIM_MAX;
   endproperty
   a_trim_reset: assert property (p_trim_reset) else $error("trim level reset wrong");

   property p_no_trim_off_analog;
      @(posedge aclk) disable iff (!aresetn)
      (!opt_reg && reference_source_select_reg != SRC_TERMINAL) |=> ref_out.freq == $past(base);
   endproperty
   a_no_trim_off_analog: assert property (p_no_trim_off_analog) else $error("trim off analog");

   property p_clamp;
      @(posedge aclk) disable iff (!aresetn)
      (trim_on && td && !tu && diff < 0) |=> ref_out.freq == 16'sh0000;
   endproperty
   a_clamp: assert property (p_clamp) else $error("negative not clamped");

   property p_pair_err;
      @(posedge aclk) disable iff (!aresetn)
      (has_tu != has_td) |=> invalid_input_selection_error;
   endproperty
   a_pair_err: assert property (p_pair_err) else $error("missing pair error");

   property p_capture;
      @(posedge aclk) disable iff (!aresetn)
      sh_capture |=> hold_active && held_ref_reg == $past(analog_ref);
   endproperty
   a_capture: assert property (p_capture) else $error("capture failed");

   property p_early_release;
      @(posedge aclk) disable iff (!aresetn)
      !sh_in |=> !hold_active && sh_cnt_reg == 32'h00000000;
   endproperty
   a_early_release: assert property (p_early_release) else $error("hold without input");

   property p_sh_conflict;
      @(posedge aclk) disable iff (!aresetn)
      (has_sh && has_tu) |=> invalid_input_selection_error;
   endproperty
   a_sh_conflict: assert property (p_sh_conflict) else $error("conflict not flagged");

   property p_src_stopped;
      @(posedge aclk) disable iff (!aresetn)
      !drive_stopped |=> $stable(opt_reg);
   endproperty
   a_src_stopped: assert property (p_src_stopped) else $error("source moved running");

   property p_opt_run;
      @(posedge aclk) disable iff (!aresetn)
      opt_reg |=> ref_out.run == $past(comm_run) && ref_out.freq == $past(comm_ref);
   endproperty
   a_opt_run: assert property (p_opt_run) else $error("option source wrong");

   c_hold: cover property (@(posedge aclk) disable iff (!aresetn) sh_capture);
   c_trim_dn: cover property (@(posedge aclk) disable iff (!aresetn) trim_on && td && !tu);
   c_switch: cover property (@(posedge aclk) disable iff (!aresetn) drive_stopped && opt_in && !opt_reg);
endmodule

/* File: frequency_reference_trim_hold_test.sv */
// self-checking bench for the reference trim and hold block
`timescale 1ns/1ps
module frequency_reference_trim_hold_test
   import trim_hold_pkg::*;
;
   logic aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, r, d32;
   logic [1:0] bresp, rresp, resp;
   logic [N_TERM-1:0] term_cmd, contacts;
   logic signed [15:0] ana_cmd, analog, comm_ref;
   logic comm_run, terminal_run, drive_stopped, err, hold, irq, u, d;
   ref_out_t ref_out;
   logic [31:0] seed;
   int errors, tests_run, pc, b;
   // ----------------------------------------
   // clock, partner and design
   // ----------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   contact_source_model src (.aclk(aclk), .term_cmd(term_cmd), .ana_cmd(ana_cmd),
      .contact_input_terminal(contacts), .analog_ref(analog));
   frequency_reference_trim_hold #(.HOLD_COUNT(20)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .contact_input_terminal(contacts), .analog_ref(analog), .comm_ref(comm_ref),
      .comm_run(comm_run), .terminal_run(terminal_run), .drive_stopped(drive_stopped),
      .ref_out(ref_out), .invalid_input_selection_error(err), .hold_active(hold), .irq(irq));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // trim amount truncates, sum saturates at full scale
   function automatic logic [15:0] exp_freq(input int b, input logic u, input logic d, input int pc);
      int t, s;
      t = 1000 * pc / 100;
      s = b;
      if (b > 0 && u && !d) s = b + t;
      if (b > 0 && d && !u) s = (b > t) ? b - t : 0;
      if (s > 32767) s = 32767;
      return s[15:0];
   endfunction
   task automatic complete_run;
      if (errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // bready and rready stay high, so every answer is taken at once
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end
      while (!bvalid && n < 100);
      resp = bresp;
      if (n == 100) errors++;
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
      end
      while (!rvalid && n < 100);
      d32 = rdata;
      resp = rresp;
      if (n == 100) errors++;
   endtask
   initial
   begin
      repeat (20000) @(posedge aclk);
      errors++;
      complete_run();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      {awvalid, wvalid, arvalid, comm_run, terminal_run, drive_stopped, aresetn} = '0;
      {awaddr, araddr, wdata, term_cmd, ana_cmd, comm_ref} = '0;
      errors = 0;
      tests_run = 0;
      seed = 32'd58484;
      cyc(12);
      aresetn <= 1'b1;
      rd(OFS_TRIM);
      check(d32, 32'h0000000A);
      rd(OFS_REF_SRC);
      check(d32, 32'h00000001);
      rd(8'h1C);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(OFS_STATUS, 32'h00000000);
      check({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(OFS_IRQ_MASK, 32'h00000007);
      wr(OFS_FSEL0, {24'h0, FN_TRIM_UP});
      cyc(3);
      check({31'h0, err & irq}, 32'h00000001);
      wr(OFS_FSEL0 + 8'h04, {24'h0, FN_TRIM_DN});
      wr(OFS_IRQ_STAT, 32'h00000007);
      cyc(3);
      check({30'h0, err, irq}, 32'h00000000);
      wr(OFS_MAXF, 32'h000003E8);
      for (int i = 0; i < 20; i++)
      begin
         r = rnd();
         pc = (i == 0) ? 100 : (i == 1) ? 0 : int'(r[31:8] % 101);
         b = (i == 0) ? 5 : int'(r[23:8] % 1400) - 200;
         u = (i == 0) ? 1'b0 : r[0];
         d = (i == 0) ? 1'b1 : r[1];
         wr(OFS_TRIM, 32'(pc));
         term_cmd <= {8'h00, d, u};
         ana_cmd <= b[15:0];
         cyc(4);
         check({16'h0, ref_out.freq}, {16'h0, exp_freq(b, u, d, pc)});
      end
      wr(OFS_REF_SRC, 32'h00000002);
      term_cmd <= 10'h001;
      ana_cmd <= 16'sd500;
      cyc(4);
      check({16'h0, ref_out.freq}, 32'h000001F4);
      wr(OFS_FSEL0 + 8'h08, {24'h0, FN_SAMPLE_HOLD});
      cyc(3);
      check({31'h0, err}, 32'h00000001);
      wr(OFS_FSEL0, 32'h00000000);
      wr(OFS_FSEL0 + 8'h04, 32'h00000000);
      term_cmd <= 10'h004;
      ana_cmd <= 16'sd300;
      cyc(10);
      term_cmd <= 10'h000;
      cyc(30);
      check({30'h0, err, hold}, 32'h00000000);
      term_cmd <= 10'h004;
      cyc(30);
      ana_cmd <= 16'sd700;
      cyc(4);
      check({15'h0, hold, ref_out.freq}, 32'h0001012C);
      term_cmd <= 10'h000;
      cyc(4);
      check({15'h0, hold, ref_out.freq}, 32'h000002BC);
      // source select: ignored while running, taken once stopped
      wr(OFS_FSEL0 + 8'h0C, {24'h0, FN_SRC_SEL});
      comm_ref <= 16'sd1234;
      comm_run <= 1'b1;
      terminal_run <= 1'b0;
      term_cmd <= 10'h008;
      cyc(4);
      check({31'h0, ref_out.option}, 32'h00000000);
      drive_stopped <= 1'b1;
      cyc(4);
      check({14'h0, ref_out.option, ref_out.run, ref_out.freq}, 32'h000304D2);
      term_cmd <= 10'h004;
      cyc(30);
      aresetn <= 1'b0;
      cyc(2);
      aresetn <= 1'b1;
      cyc(2);
      check({31'h0, hold}, 32'h00000000);
      complete_run();
   end
endmodule

/* File: trim_hold_pkg.sv */
// constants and types for the reference trim and hold block
package trim_hold_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int REF_W = 16;
   localparam int N_TERM = 10;
   localparam int CODE_W = 8;
   localparam int TRIM_W = 7;
   localparam int IRQ_W = 3;
   // function codes held in input_function_select
   localparam logic [7:0] FN_SRC_SEL = 8'h02;
   localparam logic [7:0] FN_RAMP_HOLD = 8'h0A;
   localparam logic [7:0] FN_UP = 8'h10;
   localparam logic [7:0] FN_DOWN = 8'h11;
   localparam logic [7:0] FN_TRIM_UP = 8'h1C;
   localparam logic [7:0] FN_TRIM_DN = 8'h1D;
   localparam logic [7:0] FN_SAMPLE_HOLD = 8'h1E;
   // register byte offsets
   localparam logic [7:0] OFS_TRIM = 8'h00;
   localparam logic [7:0] OFS_MAXF = 8'h04;
   localparam logic [7:0] OFS_REF_SRC = 8'h08;
   localparam logic [7:0] OFS_RUN_SRC = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
   localparam logic [7:0] OFS_FSEL0 = 8'h20;
   // reset values and limits
   localparam logic [6:0] TRIM_RESET = 7'h0A;
   localparam logic [6:0] TRIM_MAX = 7'h64;
   localparam logic [15:0] MAXF_RESET = 16'h7FFF;
   localparam logic [1:0] SRC_TERMINAL = 2'h1;
   localparam logic [22:0] PCT_DIV = 23'h000064;
   localparam logic signed [16:0] REF_CEIL = 17'sh07FFF;
   // status and interrupt bit positions
   localparam int ST_ERR = 0;
   localparam int ST_HELD = 1;
   localparam int ST_OPT = 2;
   localparam int ST_FREQ = 16;
   localparam int IRQ_ERR = 0;
   localparam int IRQ_HOLD = 1;
   localparam int IRQ_SRC = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // sample delay
   localparam int HOLD_TIME_MS = 100;
   localparam int CLK_HZ = 40_000_000;
   localparam int HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
   typedef struct packed
   {
      logic signed [15:0] freq;
      logic run;
      logic option;
   } ref_out_t;
   typedef enum {SH_IDLE, SH_WAIT, SH_HELD} sh_state_t;
endpackage
